// File: design/subroutine_call_execution.sv
// execution of the four subroutine calling jumps
// Behaviour
// - section zero memory save: flags plus pc
// - nonzero section: pc bits 6-35, top zero
// - memory-saving jump continues at e plus one
// - both pc saves clear fpd, afi, traps
// - interrupt memory save from user leaves user, clears public
// - accumulator pc save in either section, then jump e
// - pc saving jumps are unconditional
// - acc save: store ac, load halves, jump e+1
// - acc restore loads from ac left, jumps e
// - acc save/restore use in-section parts only, except the save store to full e
module subroutine_call_execution
    import subr_call_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              instr_valid,
    input  wire instr_s            instr,
    input  wire logic [ADDR_W-1:0] pc,
    input  wire logic [FLAG_W-1:0] flags_in,
    input  wire logic [WORD_W-1:0] ac_value,
    input  wire logic              mem_rd_ack,
    input  wire logic [WORD_W-1:0] mem_rd_data,
    output logic                   busy_ff,
    output mem_wr_s                mem_wr_ff,
    output logic                   mem_rd_req_ff,
    output logic [ADDR_W-1:0]      mem_rd_addr_ff,
    output ac_wr_s                 ac_wr_ff,
    output logic                   flags_wr_ff,
    output logic [FLAG_W-1:0]      flags_out_ff,
    output logic                   jump_ff,
    output logic [ADDR_W-1:0]      jump_addr_ff,
    output logic                   done_ff
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_RD} state_e;

    state_e            state_ff,       nxt_state;
    logic              nxt_busy;
    mem_wr_s           nxt_mem_wr;
    logic              nxt_mem_rd_req;
    logic [ADDR_W-1:0] nxt_mem_rd_addr;
    ac_wr_s            nxt_ac_wr;
    logic              nxt_flags_wr;
    logic [FLAG_W-1:0] nxt_flags_out;
    logic              nxt_jump;
    logic [ADDR_W-1:0] nxt_jump_addr;
    logic              nxt_done;
    logic [3:0]        rd_sel_ff,      nxt_rd_sel;
    logic [ADDR_W-1:0] rd_jump_ff,     nxt_rd_jump;
    logic [WORD_W-1:0] pc_word;

    pc_word_fmt u_fmt (
        .flags   (flags_in),
        .pc      (pc),
        .pc_word (pc_word)
    );

    // in-section address within the current section
    function automatic logic [ADDR_W-1:0] local_addr(input logic [ADDR_W-1:0] base,
                                                     input logic [HALF_W-1:0] off);
        local_addr = {base[ADDR_W-1:HALF_W], off};
    endfunction : local_addr

    // flags with the per-call bits knocked down
    function automatic logic [FLAG_W-1:0] call_flags(input logic [FLAG_W-1:0] f,
                                                     input logic              leave_user);
        logic [FLAG_W-1:0] r;
        r = f;
        r[FLAG_W-1-FLG_FPD]   = 1'b0;
        r[FLAG_W-1-FLG_AFI]   = 1'b0;
        r[FLAG_W-1-FLG_TRAP1] = 1'b0;
        r[FLAG_W-1-FLG_TRAP2] = 1'b0;
        if (leave_user) begin
            r[FLAG_W-1-FLG_USER]   = 1'b0;
            r[FLAG_W-1-FLG_PUBLIC] = 1'b0;
        end
        call_flags = r;
    endfunction : call_flags

    logic go;
    logic in_user;
    assign go      = instr_valid && instr.ea_done && (state_ff == ST_IDLE);
    assign in_user = flags_in[FLAG_W-1-FLG_USER];

    always_comb begin
        nxt_state       = state_ff;
        nxt_busy        = busy_ff;
        nxt_mem_wr      = '0;
        nxt_mem_rd_req  = 1'b0;
        nxt_mem_rd_addr = mem_rd_addr_ff;
        nxt_ac_wr       = '0;
        nxt_flags_wr    = 1'b0;
        nxt_flags_out   = flags_out_ff;
        nxt_jump        = 1'b0;
        nxt_jump_addr   = jump_addr_ff;
        nxt_done        = 1'b0;
        nxt_rd_sel      = rd_sel_ff;
        nxt_rd_jump     = rd_jump_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (go) begin
                    unique case (instr.opcode)
                        OP_SAVE_MEM: begin
                            nxt_mem_wr    = '{valid: 1'b1, addr: instr.ea, data: pc_word};
                            nxt_flags_wr  = 1'b1;
                            nxt_flags_out = call_flags(flags_in, instr.intr_instr && in_user);
                            nxt_jump      = 1'b1;
                            nxt_jump_addr = instr.ea + 30'h1;
                            nxt_done      = 1'b1;
                        end
                        OP_SAVE_AC: begin
                            nxt_ac_wr     = '{valid: 1'b1, sel: instr.ac_sel, data: pc_word};
                            nxt_flags_wr  = 1'b1;
                            nxt_flags_out = call_flags(flags_in, 1'b0);
                            nxt_jump      = 1'b1;
                            nxt_jump_addr = instr.ea;
                            nxt_done      = 1'b1;
                        end
                        OP_SAVE_ACC: begin
                            nxt_mem_wr    = '{valid: 1'b1, addr: instr.ea, data: ac_value};
                            nxt_ac_wr     = '{valid: 1'b1, sel: instr.ac_sel,
                                              data: {instr.ea[HALF_W-1:0], pc[HALF_W-1:0]}};
                            nxt_jump      = 1'b1;
                            nxt_jump_addr = local_addr(pc, instr.ea[HALF_W-1:0] + 18'h1);
                            nxt_done      = 1'b1;
                        end
                        OP_RESTORE_AC: begin
                            nxt_mem_rd_req  = 1'b1;
                            nxt_mem_rd_addr = local_addr(pc, ac_value[WORD_W-1:HALF_W]);
                            nxt_rd_sel      = instr.ac_sel;
                            nxt_rd_jump     = local_addr(pc, instr.ea[HALF_W-1:0]);
                            nxt_busy        = 1'b1;
                            nxt_state       = ST_WAIT_RD;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_WAIT_RD: begin
                // request held until acknowledged
                nxt_mem_rd_req = !mem_rd_ack;
                if (mem_rd_ack) begin
                    nxt_ac_wr     = '{valid: 1'b1, sel: rd_sel_ff, data: mem_rd_data};
                    nxt_jump      = 1'b1;
                    nxt_jump_addr = rd_jump_ff;
                    nxt_done      = 1'b1;
                    nxt_busy      = 1'b0;
                    nxt_state     = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff       <= ST_IDLE;
            busy_ff        <= 1'b0;
            mem_wr_ff      <= '0;
            mem_rd_req_ff  <= 1'b0;
            mem_rd_addr_ff <= '0;
            ac_wr_ff       <= '0;
            flags_wr_ff    <= 1'b0;
            flags_out_ff   <= FLAG_RESET;
            jump_ff        <= 1'b0;
            jump_addr_ff   <= '0;
            done_ff        <= 1'b0;
            rd_sel_ff      <= '0;
            rd_jump_ff     <= '0;
        end else begin
            state_ff       <= nxt_state;
            busy_ff        <= nxt_busy;
            mem_wr_ff      <= nxt_mem_wr;
            mem_rd_req_ff  <= nxt_mem_rd_req;
            mem_rd_addr_ff <= nxt_mem_rd_addr;
            ac_wr_ff       <= nxt_ac_wr;
            flags_wr_ff    <= nxt_flags_wr;
            flags_out_ff   <= nxt_flags_out;
            jump_ff        <= nxt_jump;
            jump_addr_ff   <= nxt_jump_addr;
            done_ff        <= nxt_done;
            rd_sel_ff      <= nxt_rd_sel;
            rd_jump_ff     <= nxt_rd_jump;
        end
    end

    a_save_mem_jump: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_MEM |=> jump_ff && jump_addr_ff == $past(instr.ea) + 30'h1)
        else $error("memory save jump target wrong");

    // top bits zero off section 0
    a_save_mem_fmt: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_MEM && pc[ADDR_W-1:HALF_W] != 12'h000
        |=> mem_wr_ff.valid && mem_wr_ff.data == {6'h00, $past(pc)})
        else $error("nonzero section pc word wrong");

    a_save_mem_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_MEM && pc[ADDR_W-1:HALF_W] == 12'h000
        |=> mem_wr_ff.data[WORD_W-1:WORD_W-FLAG_W] == $past(flags_in))
        else $error("section zero flags not saved");

    a_flags_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        flags_wr_ff |-> !flags_out_ff[FLAG_W-1-FLG_FPD] && !flags_out_ff[FLAG_W-1-FLG_AFI]
        && !flags_out_ff[FLAG_W-1-FLG_TRAP1] && !flags_out_ff[FLAG_W-1-FLG_TRAP2])
        else $error("call flags not cleared");

    a_leave_user: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_MEM && instr.intr_instr && in_user
        |=> !flags_out_ff[FLAG_W-1-FLG_USER] && !flags_out_ff[FLAG_W-1-FLG_PUBLIC])
        else $error("user mode not left");

    a_save_ac_jump: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_AC
        |=> ac_wr_ff.valid && jump_ff && jump_addr_ff == $past(instr.ea))
        else $error("accumulator save jump wrong");

    a_save_acc_halves: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_ACC
        |=> ac_wr_ff.data == {$past(instr.ea[HALF_W-1:0]), $past(pc[HALF_W-1:0])} && mem_wr_ff.valid)
        else $error("accumulator save halves wrong");

    a_restore_done: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_WAIT_RD && mem_rd_ack |=> ac_wr_ff.valid && jump_ff && state_ff == ST_IDLE)
        else $error("restore did not complete");

    a_wait_address: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_IDLE && !(instr_valid && instr.ea_done) |=> !jump_ff && !mem_wr_ff.valid)
        else $error("action before address ready");

    // flag bits the pc saves knock down, spelled out apart from call_flags
    localparam logic [FLAG_W-1:0] CLR_MASK = (FLAG_W'(1) << (FLAG_W-1-FLG_FPD)) | (FLAG_W'(1) << (FLAG_W-1-FLG_AFI))
                                           | (FLAG_W'(1) << (FLAG_W-1-FLG_TRAP1)) | (FLAG_W'(1) << (FLAG_W-1-FLG_TRAP2));

    a_save_mem_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_MEM |=> mem_wr_ff.valid && mem_wr_ff.addr == $past(instr.ea))
        else $error("memory save address wrong");

    a_save_ac_sect0: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_AC && pc[ADDR_W-1:HALF_W] == 12'h000
        |=> ac_wr_ff.data == {$past(flags_in), 5'h00, $past(pc[HALF_W-1:0])})
        else $error("section zero ac word wrong");

    a_save_ac_sectn: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_AC && pc[ADDR_W-1:HALF_W] != 12'h000
        |=> ac_wr_ff.data == {6'h00, $past(pc)})
        else $error("nonzero section ac word wrong");

    a_save_acc_store: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_ACC
        |=> mem_wr_ff.addr == $past(instr.ea) && mem_wr_ff.data == $past(ac_value))
        else $error("accumulator save store wrong");

    a_save_acc_jump: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_ACC |=> jump_ff && jump_addr_ff[ADDR_W-1:HALF_W] == $past(pc[ADDR_W-1:HALF_W])
        && jump_addr_ff[HALF_W-1:0] == $past(instr.ea[HALF_W-1:0]) + 18'h1)
        else $error("accumulator save left section");

    a_restore_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_RESTORE_AC
        |=> mem_rd_req_ff && mem_rd_addr_ff == {$past(pc[ADDR_W-1:HALF_W]), $past(ac_value[WORD_W-1:HALF_W])})
        else $error("restore pointer wrong");

    a_restore_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_ff == ST_WAIT_RD && !mem_rd_ack |=> mem_rd_req_ff && busy_ff && state_ff == ST_WAIT_RD)
        else $error("restore request dropped");

    a_pc_save_uncond: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && (instr.opcode == OP_SAVE_MEM || instr.opcode == OP_SAVE_AC)
        |=> jump_ff && flags_wr_ff && done_ff)
        else $error("pc save not unconditional");

    a_flags_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
        go && instr.opcode == OP_SAVE_AC
        |=> (flags_out_ff | CLR_MASK) == ($past(flags_in) | CLR_MASK))
        else $error("untouched flags changed");
endmodule : subroutine_call_execution

// File: design/subr_call_pkg.sv
// shared types and constants for the subroutine call execution block
package subr_call_pkg;
    localparam int          WORD_W        = 36;
    localparam int          ADDR_W        = 30;
    localparam int          HALF_W        = 18;
    localparam int          FLAG_W        = 13;
    localparam logic [8:0]  OP_SAVE_MEM   = 9'h0b4;
    localparam logic [8:0]  OP_SAVE_AC    = 9'h0b5;
    localparam logic [8:0]  OP_SAVE_ACC   = 9'h0b6;
    localparam logic [8:0]  OP_RESTORE_AC = 9'h0b7;
    // flag bit positions, numbered from the left (bit 0 = msb of flag field)
    localparam int          FLG_USER      = 5;
    localparam int          FLG_PUBLIC    = 7;
    localparam int          FLG_AFI       = 8;
    localparam int          FLG_TRAP2     = 9;
    localparam int          FLG_TRAP1     = 10;
    localparam int          FLG_FPD       = 11;
    localparam logic [5:0]  SECT_PAD      = 6'h00;
    localparam logic [12:0] FLAG_RESET    = 13'h0000;

    typedef struct packed {
        logic [8:0]        opcode;
        logic [3:0]        ac_sel;
        logic [ADDR_W-1:0] ea;
        logic              ea_done;
        logic              intr_instr;
    } instr_s;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } mem_wr_s;

    typedef struct packed {
        logic              valid;
        logic [3:0]        sel;
        logic [WORD_W-1:0] data;
    } ac_wr_s;
endpackage : subr_call_pkg

// File: design/pc_word_fmt.sv
// builds the saved pc word for section zero or nonzero section
module pc_word_fmt
    import subr_call_pkg::*;
(
    input  wire logic [FLAG_W-1:0] flags,
    input  wire logic [ADDR_W-1:0] pc,
    output logic      [WORD_W-1:0] pc_word
);
    logic sect_zero;
    assign sect_zero = (pc[ADDR_W-1:HALF_W] == 12'h000);
    always_comb begin
        if (sect_zero) begin
            pc_word = {flags, 5'h00, pc[HALF_W-1:0]};
        end else begin
            pc_word = {SECT_PAD, pc};
        end
    end
endmodule : pc_word_fmt

// File: dv/mem_model.sv
// memory side model answering restore reads and taking save writes
module mem_model
    import subr_call_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire mem_wr_s           mem_wr,
    input  wire logic              rd_req,
    input  wire logic [ADDR_W-1:0] rd_addr,
    input  wire logic [3:0]        lat,
    output logic                   rd_ack,
    output logic [WORD_W-1:0]      rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem [16];
    logic [3:0]        cnt;
    logic              sent;
    initial begin
        rd_ack = 1'b0;
        rd_data = 36'h0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 36'h900000000 | 36'(i);
        end
    end
    always @(posedge core_clk) begin
        if (mem_wr.valid) begin
            mem[mem_wr.addr[3:0]] <= mem_wr.data;
        end
        if (!sys_rst && rd_req && !sent && cnt == lat) begin
            rd_ack  <= 1'b1;
            rd_data <= mem[rd_addr[3:0]];
            sent    <= 1'b1;
        end else begin
            rd_ack  <= 1'b0;
            // data only valid in the ack cycle, so it toggles otherwise
            rd_data <= ~rd_data;
            if (sys_rst || !rd_req) begin
                cnt  <= 4'h0;
                sent <= 1'b0;
            end else if (!sent) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : mem_model

// File: dv/tb.sv
// self-checking bench for the subroutine call block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import subr_call_pkg::*;
    localparam logic [12:0] CLR = 13'h1 << (12-FLG_AFI) | 13'h1 << (12-FLG_TRAP2)
                                | 13'h1 << (12-FLG_TRAP1) | 13'h1 << (12-FLG_FPD);
    localparam logic [12:0] UBIT = 13'h1 << (12-FLG_USER);
    localparam logic [12:0] PBIT = 13'h1 << (12-FLG_PUBLIC);
    logic core_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, mem_rd_ack, busy_ff, mem_rd_req_ff;
    logic flags_wr_ff, jump_ff, done_ff;
    instr_s instr = '0;
    logic [ADDR_W-1:0] pc = '0, mem_rd_addr_ff, jump_addr_ff;
    logic [FLAG_W-1:0] flags_in = '0, flags_out_ff;
    logic [WORD_W-1:0] ac_value = '0, mem_rd_data;
    logic [3:0] lat = 4'h0;
    mem_wr_s mem_wr_ff;
    ac_wr_s ac_wr_ff;
    int bad_count = 0, n_checks = 0, cycles = 0;
    subroutine_call_execution i_subroutine_call_execution (.core_clk(core_clk), .sys_rst(sys_rst),
        .instr_valid(instr_valid), .instr(instr), .pc(pc), .flags_in(flags_in), .ac_value(ac_value),
        .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .busy_ff(busy_ff), .mem_wr_ff(mem_wr_ff),
        .mem_rd_req_ff(mem_rd_req_ff), .mem_rd_addr_ff(mem_rd_addr_ff), .ac_wr_ff(ac_wr_ff),
        .flags_wr_ff(flags_wr_ff), .flags_out_ff(flags_out_ff), .jump_ff(jump_ff),
        .jump_addr_ff(jump_addr_ff), .done_ff(done_ff));
    mem_model i_mem_model (.core_clk(core_clk), .sys_rst(sys_rst), .mem_wr(mem_wr_ff), .rd_req(mem_rd_req_ff),
        .rd_addr(mem_rd_addr_ff), .lat(lat), .rd_ack(mem_rd_ack), .rd_data(mem_rd_data));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // presents one instruction for one cycle, returns while the answer pulses stand
    task automatic go(logic [8:0] op, logic [ADDR_W-1:0] e, logic intr, logic rdy);
        // an idle edge first, so valid is never lowered and raised in one step
        @(negedge core_clk);
        // reserved accumulator field kept zero on memory save
        instr = '{op, (op == OP_SAVE_MEM) ? 4'h0 : 4'h5, e, rdy, intr};
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_valid = 1'b0;
    endtask : go
    task automatic t_save_mem();
        for (int i = 0; i < 6; i++) begin
            pc = i[0] ? 30'h00150042 : 30'h00021234;
            flags_in = i[1] ? 13'h1fff : 13'h0a5a;
            if (i > 3) flags_in = i[0] ? 13'h1fff : 13'h1fff & ~UBIT;
            go(OP_SAVE_MEM, 30'h00030100, i > 3, 1'b1);
            chk("mem_wr data", i[0] ? {6'h0, pc} : {flags_in, 5'h0, pc[17:0]}, mem_wr_ff.data);
            chk("mem_wr valid addr", {1'b1, 30'h00030100}, {mem_wr_ff.valid, mem_wr_ff.addr});
            chk("jump addr", {2'b11, 30'h00030101}, {jump_ff, done_ff, jump_addr_ff});
            chk("flags", {1'b1, flags_in & ~CLR & ~((i == 5) ? UBIT | PBIT : 13'h0)},
                {flags_wr_ff, flags_out_ff});
        end
        $display("test save_mem done");
    endtask : t_save_mem
    task automatic t_save_ac();
        for (int i = 0; i < 2; i++) begin
            pc = i[0] ? 30'h00150042 : 30'h00021234;
            flags_in = 13'h1fff;
            go(OP_SAVE_AC, 30'h00030200, 1'b1, 1'b1);
            chk("ac_wr", {2'b10, 4'h5, i[0] ? {6'h0, pc} : {flags_in, 5'h0, pc[17:0]}},
                {ac_wr_ff.valid, mem_wr_ff.valid, ac_wr_ff.sel, ac_wr_ff.data});
            chk("jump", {1'b1, 30'h00030200}, {jump_ff, jump_addr_ff});
            chk("flags", {1'b1, 13'h1fff & ~CLR}, {flags_wr_ff, flags_out_ff});
        end
        $display("test save_ac done");
    endtask : t_save_ac
    task automatic t_save_acc();
        pc = 30'h00150042;
        ac_value = 36'h123456789;
        go(OP_SAVE_ACC, 30'h000bffff, 1'b0, 1'b1);
        chk("mem_wr", {1'b1, 30'h000bffff, ac_value}, mem_wr_ff);
        chk("ac_wr", {1'b1, 18'h3ffff, 18'h10042}, {ac_wr_ff.valid, ac_wr_ff.data});
        chk("jump", {2'b10, 30'h00140000}, {jump_ff, flags_wr_ff, jump_addr_ff});
        $display("test save_acc done");
    endtask : t_save_acc
    task automatic t_restore();
        bit wr_seen;
        for (int i = 0; i < 2; i++) begin
            lat = i[0] ? 4'h3 : 4'h0;
            wr_seen = 0;
            pc = 30'h00150042;
            ac_value = {18'h20007, 18'h0};
            go(OP_RESTORE_AC, 30'h000b0021, 1'b0, 1'b1);
            chk("read req", {2'b11, 30'h00160007}, {busy_ff, mem_rd_req_ff, mem_rd_addr_ff});
            // a second instruction while busy must be ignored
            @(negedge core_clk);
            instr = '{OP_SAVE_MEM, 4'h0, 30'h00000300, 1'b1, 1'b0};
            instr_valid = 1'b1;
            @(negedge core_clk);
            instr_valid = 1'b0;
            for (int n = 0; n < 20; n++) begin
                wr_seen |= mem_wr_ff.valid;
                if (done_ff === 1'b1) break;
                @(negedge core_clk);
            end
            chk("ignored write", 36'h0, wr_seen);
            chk("ac load", {1'b1, 4'h5, 36'h900000007}, {ac_wr_ff.valid, ac_wr_ff.sel, ac_wr_ff.data});
            chk("jump", {4'b1000, 30'h00170021}, {jump_ff, busy_ff, mem_rd_req_ff, flags_wr_ff, jump_addr_ff});
        end
        $display("test restore done");
    endtask : t_restore
    task automatic t_not_ready();
        go(OP_SAVE_MEM, 30'h00000400, 1'b0, 1'b0);
        chk("no action", 36'h0, {done_ff, mem_wr_ff.valid, jump_ff});
        // an opcode outside the four must do nothing at all
        go(9'h0b3, 30'h00000400, 1'b0, 1'b1);
        chk("other opcode", 36'h0, {done_ff, busy_ff, mem_wr_ff.valid, ac_wr_ff.valid, jump_ff});
        $display("test not_ready done");
    endtask : t_not_ready
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    // hang guard, far above the fewer than fifty cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        t_save_mem();
        t_save_ac();
        t_save_acc();
        t_restore();
        t_not_ready();
        results();
    end
endmodule : tb
